/* File: lin_sbc_defs.svh */
`ifndef LIN_SBC_DEFS_SVH
`define LIN_SBC_DEFS_SVH

`define SLEW_CTRL_OFS 12'h004
`define TSD_CTRL_OFS 12'h005
`define WDT_TRIG_OFS 12'h006
`define LSD_DATA_OFS 12'h007
`define DEV_CFG_OFS 12'h003
`define SLEW_CTRL_ADDR 12'h010
`define TSD_CTRL_ADDR 12'h014
`define WDT_TRIG_ADDR 12'h018
`define LSD_DATA_ADDR 12'h01C
`define DEV_CFG_ADDR 12'h00C
`define WDT_STAT_ADDR 12'h020

`define SLEW_CTRL_RST 8'h01
`define TSD_CTRL_RST 8'h00
`define LSD_DATA_RST 8'h00
`define DEV_CFG_RST 8'h0B

`define SLEW_CTRL_MASK 8'h01
`define TSD_CTRL_MASK 8'h01
`define LSD_DATA_MASK 8'h03

`define CFG_LSD1_EN_BIT 0
`define CFG_LSD2_EN_BIT 1
`define LSD1_GATE_BIT 0
`define LSD2_GATE_BIT 1
`define SLEW_HIGH_BIT 0
`define TSD_REQ_BIT 0
`define WDT_TRIG_BIT 0

`define SYS_CLK_HZ 125000000
`define WDT_CLK_HZ 128000
`define WDT_CLR_PERIODS 2
`define WDT_DIV_CYCLES (`SYS_CLK_HZ / `WDT_CLK_HZ)
`define WDT_CLR_CYCLES (`WDT_CLR_PERIODS * `WDT_DIV_CYCLES)
`define WDT_INIT 16'h0000
`define WDT_WIN_OPEN 16'h0040
`define WDT_WIN_CLOSE 16'h0080
`define RST_PULSE_TICKS 8'h10
`endif

/* File: lin_sbc_pkg.sv */
package lin_sbc_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic lsd1_en;
        logic lsd2_en;
        logic lsd1_gate;
        logic lsd2_gate;
        logic slew_high;
        logic shutdown;
    } drv_ctrl_s;

    typedef enum logic [1:0] {
        WDT_IDLE,
        WDT_CLEAR
    } trig_state_e;
endpackage

/* File: window_watchdog.sv */
`timescale 1ns/1ns
`include "lin_sbc_defs.svh"
module window_watchdog #(
    parameter int unsigned DIV_CYCLES = `WDT_DIV_CYCLES,
    parameter logic [15:0] WIN_OPEN = `WDT_WIN_OPEN,
    parameter logic [15:0] WIN_CLOSE = `WDT_WIN_CLOSE
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic trigger_i,
    output logic tick_o,
    output logic [15:0] count_o,
    output logic fault_o
);
    typedef struct packed {
        logic [15:0] div;
        logic [15:0] count;
        logic tick;
        logic fault;
    } wdt_state_s;

    wdt_state_s s_r;
    wdt_state_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.fault = 1'b0;
        if (s_r.div == 16'(DIV_CYCLES - 1))
        begin
            s_nxt.div = 16'h0000;
            s_nxt.tick = 1'b1;
            if (s_r.count != 16'hFFFF)
            begin
                s_nxt.count = s_r.count + 16'h0001;
            end
        end
        else
        begin
            s_nxt.div = s_r.div + 16'h0001;
        end
        if (trigger_i)
        begin
            // A trigger too early or too late is a window violation.
            if (s_r.count < WIN_OPEN || s_r.count >= WIN_CLOSE)
            begin
                s_nxt.fault = 1'b1;
            end
            s_nxt.count = `WDT_INIT;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;
    assign count_o = s_r.count;
    assign fault_o = s_r.fault;
endmodule

/* File: lin_sbc_control_registers.sv */
`timescale 1ns/1ns
`include "lin_sbc_defs.svh"
module lin_sbc_control_registers #(
    parameter logic [7:0] RST_PULSE_TICKS = `RST_PULSE_TICKS
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire lin_sbc_pkg::apb_req_s apb_req_i,
    output lin_sbc_pkg::apb_rsp_s apb_rsp_o,
    output lin_sbc_pkg::drv_ctrl_s drv_ctrl_o,
    output logic reset_out_o
);
    import lin_sbc_pkg::*;

    typedef struct packed {
        logic [7:0] slew;
        logic [7:0] tsd;
        logic [7:0] trig;
        logic [7:0] lsd;
        logic [7:0] cfg;
        trig_state_e tstate;
        logic [1:0] tick_cnt;
        logic [7:0] rst_cnt;
        logic rst_out;
        logic [7:0] fault_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        drv_ctrl_s drv;
    } regs_state_s;

    regs_state_s s_r;
    regs_state_s s_nxt;
    logic wdt_tick;
    logic [15:0] wdt_count;
    logic wdt_fault;
    logic trig_pulse;
    logic setup;
    logic access;
    logic wr;

    ////////////////////////////////////////////////////////////////////////
    // The answer is staged at the setup edge so that pready and read data
    // leave flip-flops with no wait state. A write, trigger included, lands
    // only at the access edge where the master samples pready high, so an
    // aborted or stretched transfer never half-commits.

    assign setup = apb_req_i.psel && !apb_req_i.penable;
    assign access = apb_req_i.psel && apb_req_i.penable && s_r.pready;
    assign wr = access && apb_req_i.pwrite;
    assign trig_pulse = wr && apb_req_i.paddr == `WDT_TRIG_ADDR
        && apb_req_i.pwdata[`WDT_TRIG_BIT];

    window_watchdog u_wdt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .trigger_i(trig_pulse),
        .tick_o(wdt_tick),
        .count_o(wdt_count),
        .fault_o(wdt_fault)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (setup)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            unique case (apb_req_i.paddr)
                `DEV_CFG_ADDR:
                begin
                    s_nxt.prdata[7:0] = s_r.cfg;
                end
                `SLEW_CTRL_ADDR:
                begin
                    s_nxt.prdata[7:0] = s_r.slew;
                end
                `TSD_CTRL_ADDR:
                begin
                    s_nxt.prdata[7:0] = s_r.tsd;
                end
                `WDT_TRIG_ADDR:
                begin
                    // Write-only: reads return zero.
                end
                `LSD_DATA_ADDR:
                begin
                    s_nxt.prdata[7:0] = s_r.lsd;
                end
                `WDT_STAT_ADDR:
                begin
                    // Bit 17 shows the pending trigger bit, so software can
                    // watch it clear itself.
                    s_nxt.prdata = {s_r.fault_cnt, 6'h00, s_r.trig[0],
                        s_r.rst_out, wdt_count};
                end
                default:
                begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        if (wr)
        begin
            unique case (apb_req_i.paddr)
                `DEV_CFG_ADDR:
                begin
                    s_nxt.cfg = apb_req_i.pwdata[7:0];
                end
                `SLEW_CTRL_ADDR:
                begin
                    // Reserved bits are dropped on write and read zero.
                    s_nxt.slew = apb_req_i.pwdata[7:0] & `SLEW_CTRL_MASK;
                end
                `TSD_CTRL_ADDR:
                begin
                    s_nxt.tsd = apb_req_i.pwdata[7:0] & `TSD_CTRL_MASK;
                end
                `WDT_TRIG_ADDR:
                begin
                    if (trig_pulse)
                    begin
                        s_nxt.trig = 8'h01;
                        s_nxt.tstate = WDT_CLEAR;
                        s_nxt.tick_cnt = 2'b00;
                    end
                end
                `LSD_DATA_ADDR:
                begin
                    s_nxt.lsd = apb_req_i.pwdata[7:0] & `LSD_DATA_MASK;
                end
                default:
                begin
                    // Unmapped and read-only words ignore writes.
                end
            endcase
        end

        // The trigger bit self-clears on the second watchdog tick after it is set, one to two periods later.
        unique case (s_r.tstate)
            WDT_IDLE:
            begin
            end
            WDT_CLEAR:
            begin
                if (wdt_tick && !trig_pulse)
                begin
                    if (s_r.tick_cnt == 2'(`WDT_CLR_PERIODS - 1))
                    begin
                        s_nxt.trig = 8'h00;
                        s_nxt.tstate = WDT_IDLE;
                    end
                    else
                    begin
                        s_nxt.tick_cnt = s_r.tick_cnt + 2'b01;
                    end
                end
            end
            default:
            begin
                s_nxt.tstate = WDT_IDLE;
            end
        endcase

        // Reset output is held for a fixed number of watchdog ticks.
        if (wdt_fault)
        begin
            s_nxt.rst_out = 1'b1;
            s_nxt.rst_cnt = RST_PULSE_TICKS;
            if (s_r.fault_cnt != 8'hFF)
            begin
                s_nxt.fault_cnt = s_r.fault_cnt + 8'h01;
            end
        end
        else if (s_r.rst_out && wdt_tick)
        begin
            if (s_r.rst_cnt <= 8'h01)
            begin
                s_nxt.rst_out = 1'b0;
                s_nxt.rst_cnt = 8'h00;
            end
            else
            begin
                s_nxt.rst_cnt = s_r.rst_cnt - 8'h01;
            end
        end

        s_nxt.drv.lsd1_en = s_nxt.cfg[`CFG_LSD1_EN_BIT];
        s_nxt.drv.lsd2_en = s_nxt.cfg[`CFG_LSD2_EN_BIT];
        s_nxt.drv.lsd1_gate = s_nxt.lsd[`LSD1_GATE_BIT];
        s_nxt.drv.lsd2_gate = s_nxt.lsd[`LSD2_GATE_BIT];
        s_nxt.drv.slew_high = s_nxt.slew[`SLEW_HIGH_BIT];
        s_nxt.drv.shutdown = s_nxt.tsd[`TSD_REQ_BIT];
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r <= '0;
            s_r.slew <= `SLEW_CTRL_RST;
            s_r.tsd <= `TSD_CTRL_RST;
            s_r.lsd <= `LSD_DATA_RST;
            s_r.cfg <= `DEV_CFG_RST;
            s_r.tstate <= WDT_IDLE;
            s_r.drv.lsd1_en <= 1'b1;
            s_r.drv.lsd2_en <= 1'b1;
            s_r.drv.slew_high <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp_o.pready = s_r.pready;
    assign apb_rsp_o.pslverr = s_r.pslverr;
    assign apb_rsp_o.prdata = s_r.prdata;
    assign drv_ctrl_o = s_r.drv;
    assign reset_out_o = s_r.rst_out;
endmodule

/* File: lin_sbc_props.sv */
`timescale 1ns/1ns
`include "lin_sbc_defs.svh"
module lin_sbc_props (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire lin_sbc_pkg::apb_req_s apb_req_i,
    input wire lin_sbc_pkg::apb_rsp_s apb_rsp_o,
    input wire lin_sbc_pkg::drv_ctrl_s drv_ctrl_o,
    input wire logic reset_out_o
);
    import lin_sbc_pkg::*;
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic st;
    logic acc;
    logic wr;
    logic [7:0] d;
    logic [11:0] a;
    logic trg;
    // Writes land at the access edge, where the master sees pready high.
    assign st = apb_req_i.psel & ~apb_req_i.penable;
    assign acc = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready;
    assign wr = acc & apb_req_i.pwrite;
    assign d = apb_req_i.pwdata[7:0];
    assign a = apb_req_i.paddr;
    assign trg = wr && a == `WDT_TRIG_ADDR && d[0];
    ////////////////////////////////////////////////////////////////////
    chk_ready_follows: assert property (st |=> apb_rsp_o.pready)
        else $error("ready missing after setup");
    chk_ready_pulse: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("ready held too long");
    chk_cfg_drv2: assert property (
        wr && a == `DEV_CFG_ADDR |=> drv_ctrl_o.lsd2_en == $past(d[1]))
        else $error("bad enable 2");
    chk_cfg_drv1: assert property (
        wr && a == `DEV_CFG_ADDR |=> drv_ctrl_o.lsd1_en == $past(d[0]))
        else $error("bad enable 1");
    chk_slew_mode: assert property (
        wr && a == `SLEW_CTRL_ADDR |=> drv_ctrl_o.slew_high == $past(d[0]))
        else $error("bad slew");
    chk_shutdown_req: assert property (
        wr && a == `TSD_CTRL_ADDR |=> drv_ctrl_o.shutdown == $past(d[0]))
        else $error("bad shutdown");
    chk_gate_two: assert property (
        wr && a == `LSD_DATA_ADDR |=> drv_ctrl_o.lsd2_gate == $past(d[1]))
        else $error("bad gate 2");
    chk_gate_one: assert property (
        wr && a == `LSD_DATA_ADDR |=> drv_ctrl_o.lsd1_gate == $past(d[0]))
        else $error("bad gate 1");
    chk_reset_cause: assert property (
        $rose(reset_out_o) |-> $past(trg) || $past(trg, 2))
        else $error("reset without trigger");
    chk_reset_hold: assert property (
        $rose(reset_out_o) |=> reset_out_o [*8])
        else $error("reset pulse too short");
    cover property (trg);
    cover property ($rose(reset_out_o));
    cover property (apb_rsp_o.pslverr);
endmodule
bind lin_sbc_control_registers lin_sbc_props props_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .drv_ctrl_o(drv_ctrl_o),
    .reset_out_o(reset_out_o));

/* File: testbench.sv */
`timescale 1ns/1ns
`include "lin_sbc_defs.svh"
module testbench;
    import lin_sbc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    drv_ctrl_s drv;
    logic rst_o;
    int fails = 0;
    int comparisons = 0;
    int i;
    logic [31:0] rd;
    logic err;
    logic in_win;
    lin_sbc_control_registers uut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .drv_ctrl_o(drv), .reset_out_o(rst_o));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge sys_clk_i);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        do @(posedge sys_clk_i); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd);
        // The write lands at the edge that ends the access; look after it.
        @(negedge sys_clk_i);
    endtask
    task automatic rdck(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic close_out();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial forever #4 sys_clk_i = ~sys_clk_i;
    // The watchdog is walked into its open window at its real rate, about 72 ticks or 70k cycles.
    initial
    begin
        #700000;
        fails++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        check(drv, 32'h32);
        check(rst_o, 32'h0);
        rdck(`DEV_CFG_ADDR, 32'h0B);
        rdck(`SLEW_CTRL_ADDR, 32'h01);
        rdck(`TSD_CTRL_ADDR, 32'h00);
        rdck(`LSD_DATA_ADDR, 32'h00);
        rdck(`WDT_TRIG_ADDR, 32'h00);
        for (i = 0; i < 4; i++)
        begin
            wr(`DEV_CFG_ADDR, 32'h08 | 32'(i));
            check(drv.lsd2_en, 32'(i >> 1));
            check(drv.lsd1_en, 32'(i & 1));
            wr(`LSD_DATA_ADDR, 32'hFC | 32'(3 - i));
            check(drv.lsd2_gate, 32'((3 - i) >> 1));
            check(drv.lsd1_gate, 32'((3 - i) & 1));
            rdck(`LSD_DATA_ADDR, 32'(3 - i));
        end
        for (i = 0; i < 2; i++)
        begin
            wr(`SLEW_CTRL_ADDR, 32'hFE | 32'(i));
            check(drv.slew_high, 32'(i));
            rdck(`SLEW_CTRL_ADDR, 32'(i));
            wr(`TSD_CTRL_ADDR, 32'hFE | 32'(1 - i));
            check(drv.shutdown, 32'(1 - i));
            rdck(`TSD_CTRL_ADDR, 32'(1 - i));
        end
        xfer(1'b0, 12'h040, 32'h0);
        check(err, 32'h1);
        check(rd, 32'h0);
        // Right after reset the counter sits below the window opening.
        wr(`WDT_TRIG_ADDR, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        check(rst_o, 32'h1);
        xfer(1'b0, `WDT_STAT_ADDR, 32'h0);
        check(rd[15:0] < 16'h0002, 32'h1);
        check(rd[16], 32'h1);
        check(rd[17], 32'h1);
        repeat (`WDT_CLR_CYCLES) @(posedge sys_clk_i);
        rdck(`WDT_TRIG_ADDR, 32'h0);
        xfer(1'b0, `WDT_STAT_ADDR, 32'h0);
        check(rd[17], 32'h0);
        repeat (70 * `WDT_DIV_CYCLES) @(posedge sys_clk_i);
        check(rst_o, 32'h0);
        xfer(1'b0, `WDT_STAT_ADDR, 32'h0);
        in_win = rd[15:0] >= `WDT_WIN_OPEN && rd[15:0] < `WDT_WIN_CLOSE;
        check(in_win, 32'h1);
        wr(`WDT_TRIG_ADDR, 32'h1);
        repeat (4) @(posedge sys_clk_i);
        check(rst_o, 32'h0);
        xfer(1'b0, `WDT_STAT_ADDR, 32'h0);
        check(rd[15:0] < 16'h0002, 32'h1);
        check(rd[17], 32'h1);
        close_out();
    end
endmodule
